// >>> verification/comparator_reference_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module comparator_reference_control_tb
	import crc_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req, we, fio, ncfg, pcfg, c1, c2;
	logic [7:0] adr, v;
	logic [31:0] dat;
	wire [31:0] rd;
	wire [7:0] tn, td;
	wire ack, err, l_en, l_src, oe, div, fix, pp, pset, prst, tg, se;
	logic ce = 1'b1;
	crc_ref_t r1, r2, cp, cn, ap, an;
	crc_pin_t pm;
	logic [32:0] q[$];
	int bad_count = 0, samples_checked = 0, seed = 54, cyc_n = 0;
	int n_set = 0, n_rst = 0, i;
	crc_ctrl i_dut (.clk(clk), .srst(srst), .clk_en(ce),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.wb_err_o(err), .cmp1_out(c1), .cmp2_out(c2),
		.fast_internal_oscillator(fio), .adc_neg_ref_cfg(ncfg),
		.adc_pos_ref_cfg(pcfg), .ladder_enable(l_en), .ladder_source(l_src),
		.ladder_tap_num(tn), .ladder_tap_den(td),
		.ladder_pin_output_enable(oe), .divider_current_enable(div),
		.fixed_ref_enable(fix), .cmp1_ref_src(r1), .cmp2_ref_src(r2),
		.cmp_pos_ref(cp), .cmp_neg_ref(cn), .adc_pos_ref(ap),
		.adc_neg_ref(an), .ref_minus_pin(pm), .ref_plus_pin(pp),
		.latch_pulse_set(pset), .latch_pulse_reset(prst),
		.cmp2_timer_gate_sel(tg), .cmp2_sync_enable(se));
	always #10 clk = ~clk;
	// compare one value
	task chk(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one classic wishbone cycle, read expectation queued
	task bus(input logic w, input logic [7:0] a, d, input logic [32:0] e);
		if (!w)
			q.push_back(e);
		@(posedge clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'($random(seed)), d};
		// wait for the answer; only the bench timeout ends a hang
		do
			@(posedge clk);
		while (!(ack | err));
		req <= 1'b0;
		@(posedge clk);
	endtask : bus
	task finish_test();
		// reads that never got an answer count as mismatches
		bad_count += q.size();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// read watcher, pulse counters and timeout
	always @(posedge clk)
	begin
		cyc_n++;
		n_set += pset;
		n_rst += prst;
		if ((ack | err) && !we)
			chk({err, rd}, q.pop_front());
		if (cyc_n == 5000)
		begin
			bad_count++;
			finish_test();
		end
	end
	// main sequence
	initial
	begin
		{req, we, fio, ncfg, pcfg, c2} = '0;
		c1 = 1'b1;
		adr = 8'h00;
		dat = 32'h0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		bus(1'b0, 8'h00, 8'h00, 33'h0);
		bus(1'b0, 8'h04, 8'h00, 33'h82);
		bus(1'b0, 8'h08, 8'h00, 33'h0);
		bus(1'b0, 8'h10, 8'h00, 33'h100000000);
		$display("reset test done");
		for (i = 0; i < 16; i++)
		begin
			v = 8'($random(seed));
			v[3:0] = i[3:0];
			bus(1'b1, 8'h00, v, 33'h0);
			bus(1'b0, 8'h00, 8'h00, {25'h0, v});
			@(negedge clk);
			chk(l_en, v[7]);
			chk(l_src, v[4]);
			chk(oe, v[6]);
			chk({tn, td}, v[5] ? {4'h0, v[3:0], 8'h18}
				: {8'h08 + v[3:0], 8'h20});
		end
		$display("ladder test done");
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			ncfg <= i[3];
			pcfg <= i[2];
			bus(1'b1, 8'h00, {1'b1, i[0], 1'b0, i[1], 4'h0}, 33'h0);
			@(negedge clk);
			chk(cp, i[1] ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY);
			chk(cn, (i[1] && (!i[0] || i[3])) ? 2'h1 : 2'h0);
			chk(ap, i[2] ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY);
			chk(an, i[3] ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY);
			chk(pp, i[2] | i[1]);
			chk(pm, i[3] ? 2'h1 : i[0] ? 2'h3 : {1'b0, i[1]});
		end
		$display("pin test done");
		for (i = 0; i < 4; i++)
		begin
			v = 8'($random(seed));
			v[5:4] = i[1:0];
			bus(1'b1, 8'h04, v, 33'h0);
			bus(1'b0, 8'h04, 8'h00, {25'h2, v[5:4], 2'h0, v[1:0]});
			@(negedge clk);
			chk(r1, v[5] ? CRC_REF_LADDER : CRC_REF_FIXED);
			chk(r2, v[4] ? CRC_REF_LADDER : CRC_REF_FIXED);
			chk(div, v[5] | v[4]);
			chk({tg, se}, v[1:0]);
		end
		$display("select test done");
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			fio <= i[1];
			bus(1'b1, 8'h08, {6'h03, 1'b0, i[0]}, 33'h0);
			repeat (4) @(posedge clk);
			bus(1'b0, 8'h08, 8'h00, {32'h0, i[0]});
			@(negedge clk);
			chk(fix, i[0] | i[1]);
		end
		chk(n_set, 33'h4);
		chk(n_rst, 33'h4);
		bus(1'b0, 8'h0C, 8'h00, 33'h7);
		$display("latch test done");
		// clock enable low holds the bus and the registers
		ce <= 1'b0;
		fork
			bus(1'b1, 8'h00, 8'h35, 33'h0);
			begin
				repeat (6) @(posedge clk);
				chk({ack, l_en}, 33'h1);
				ce <= 1'b1;
			end
		join
		@(negedge clk);
		chk({l_en, l_src, tn}, 33'h105);
		$display("enable test done");
		// second reset in mid-run restores the reset values
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		bus(1'b0, 8'h00, 8'h00, 33'h0);
		bus(1'b0, 8'h04, 8'h00, 33'h82);
		$display("second reset test done");
		finish_test();
	end
endmodule : comparator_reference_control_tb
`default_nettype wire

// >>> verification/crc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// decode and bus checker
// ----------------------------------------
module crc_ctrl_sva
	import crc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic fast_internal_oscillator,
	input wire logic adc_neg_ref_cfg,
	input wire logic adc_pos_ref_cfg,
	input wire logic ladder_source,
	input wire logic [7:0] ladder_tap_num,
	input wire logic [7:0] ladder_tap_den,
	input wire logic ladder_pin_output_enable,
	input wire logic divider_current_enable,
	input wire logic fixed_ref_enable,
	input wire crc_ref_t cmp1_ref_src,
	input wire crc_ref_t cmp2_ref_src,
	input wire crc_ref_t cmp_neg_ref,
	input wire crc_ref_t adc_pos_ref,
	input wire logic ref_plus_pin,
	input wire crc_pin_t ref_minus_pin,
	input wire logic latch_pulse_set
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// fast oscillator forces the fixed reference
	property p_fix; fast_internal_oscillator |-> fixed_ref_enable; endproperty
	a_fix: assert property (p_fix)
		else $error("fixed reference off");
	// divider current follows either ladder selection
	property p_div; divider_current_enable == (cmp1_ref_src == CRC_REF_LADDER
		|| cmp2_ref_src == CRC_REF_LADDER); endproperty
	a_div: assert property (p_div)
		else $error("divider current wrong");
	// selection only moves on a bus write
	property p_sel; $changed(cmp1_ref_src) || $changed(ladder_source)
		|-> wb_ack_o; endproperty
	a_sel: assert property (p_sel)
		else $error("select changed without write");
	property p_adc; adc_pos_ref == (adc_pos_ref_cfg ? CRC_REF_EXTERNAL
		: CRC_REF_SUPPLY); endproperty
	a_adc: assert property (p_adc)
		else $error("adc positive reference wrong");
	property p_cneg; cmp_neg_ref == ((ladder_source && (adc_neg_ref_cfg
		|| !ladder_pin_output_enable)) ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY);
	endproperty
	a_cneg: assert property (p_cneg)
		else $error("comparator negative reference wrong");
	property p_plus; ref_plus_pin == (adc_pos_ref_cfg | ladder_source);
	endproperty
	a_plus: assert property (p_plus)
		else $error("plus pin function wrong");
	property p_minus; ref_minus_pin == (adc_neg_ref_cfg ? CRC_PIN_EXT_REF
		: ladder_pin_output_enable ? CRC_PIN_LADDER
		: ladder_source ? CRC_PIN_EXT_REF : CRC_PIN_GPIO); endproperty
	a_minus: assert property (p_minus)
		else $error("minus pin function wrong");
	property p_tap; (ladder_tap_den == 8'h18 && ladder_tap_num < 8'h10)
		|| (ladder_tap_den == 8'h20 && ladder_tap_num >= 8'h08
		&& ladder_tap_num < 8'h18); endproperty
	a_tap: assert property (p_tap)
		else $error("tap fraction out of range");
	// a frozen cycle takes no request, so only enabled cycles count
	property p_ack; clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o
		&& !wb_err_o |=> wb_ack_o ^ wb_err_o; endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer missing");
	property p_pul; latch_pulse_set && clk_en |=> !latch_pulse_set;
	endproperty
	a_pul: assert property (p_pul)
		else $error("set pulse too long");
	c_pul: cover property (latch_pulse_set);
	c_lad: cover property (ref_minus_pin == CRC_PIN_LADDER);
	c_err: cover property (wb_err_o);
endmodule : crc_ctrl_sva
bind crc_ctrl crc_ctrl_sva i_sva (.clk, .srst, .clk_en, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_err_o, .fast_internal_oscillator, .adc_neg_ref_cfg,
	.adc_pos_ref_cfg, .ladder_source, .ladder_tap_num, .ladder_tap_den,
	.ladder_pin_output_enable, .divider_current_enable, .fixed_ref_enable,
	.cmp1_ref_src, .cmp2_ref_src, .cmp_neg_ref, .adc_pos_ref,
	.ref_plus_pin, .ref_minus_pin, .latch_pulse_set);
`default_nettype wire

// >>> verilog/crc_consts.svh
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// register byte offsets on the wishbone bus
`define CRC_OFS_LADDER 8'h00
`define CRC_OFS_CMP2 8'h04
`define CRC_OFS_LATCH 8'h08
`define CRC_OFS_STATUS 8'h0C

// reset values
`define CRC_RST_LADDER 8'h00
`define CRC_RST_CMP2 8'h02
`define CRC_RST_LATCH 8'h00

// ladder control fields
`define CRC_LAD_EN 7
`define CRC_LAD_OE 6
`define CRC_LAD_RANGE 5
`define CRC_LAD_SRC 4

// comparator two control fields
`define CRC_CMP_MC1 7
`define CRC_CMP_MC2 6
`define CRC_CMP_SEL1 5
`define CRC_CMP_SEL2 4
`define CRC_CMP_WMASK 8'h33

// latch control fields
`define CRC_LAT_PSET 3
`define CRC_LAT_PRST 2
`define CRC_LAT_FIXED 0
`define CRC_LAT_WMASK 8'hF1

// ladder tap arithmetic: low range steps of 1/24, high of 1/32
`define CRC_LOW_DEN 8'h18
`define CRC_HIGH_DEN 8'h20
`define CRC_HIGH_BASE 8'h08

`endif

// >>> verilog/crc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "crc_consts.svh"

// Operation
// - ladder powered only while ladder enable bit is one
// - range bit one selects low range; four-bit level picks one of 16 taps
// - low tap is level/24 of span; high is 1/4 plus level/32
// - source select one uses external ref pins, zero the supply rails
// - pin output enable connects ladder output to reference-minus pin unless adc negative cfg is set
// - comparator one gets ladder when its select is one, else fixed
// - comparator two gets ladder when its select is one, else fixed
// - divider current flows while either comparator select bit is one
// - fixed reference on by its bit or while fast oscillator runs
// - comparator refs follow source select, output enable and adc negative cfg
// - adc refs follow the adc positive and negative configuration bits
// - reference-minus pin function decoded with adc negative cfg priority
// - reference-plus pin is external ref when adc pos cfg or source select
// - ladder control fully read/write, resets to zero on every reset
// - latch pulse bits set by software, cleared by hardware after pulse
module crc_ctrl
	import crc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// status and configuration inputs
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	input wire logic fast_internal_oscillator,
	input wire logic adc_neg_ref_cfg,
	input wire logic adc_pos_ref_cfg,
	// analog controls
	output logic ladder_enable,
	output logic ladder_source,
	output logic [7:0] ladder_tap_num,
	output logic [7:0] ladder_tap_den,
	output logic ladder_pin_output_enable,
	output logic divider_current_enable,
	output logic fixed_ref_enable,
	output crc_ref_t cmp1_ref_src,
	output crc_ref_t cmp2_ref_src,
	output crc_ref_t cmp_pos_ref,
	output crc_ref_t cmp_neg_ref,
	output crc_ref_t adc_pos_ref,
	output crc_ref_t adc_neg_ref,
	output crc_pin_t ref_minus_pin,
	output logic ref_plus_pin,
	// latch pulse controls, one cycle each
	output logic latch_pulse_set,
	output logic latch_pulse_reset,
	// comparator two control bits not used here
	output logic cmp2_timer_gate_sel,
	output logic cmp2_sync_enable
);

	//--------------------------------------------------
	// registers and bus decode
	//--------------------------------------------------
	logic [7:0] ladder_reference_control;
	logic [7:0] comparator_two_control_one;
	logic [7:0] latch_and_fixed_ref_control;
	crc_bus_t bus_state;
	logic req;
	logic hit_ladder;
	logic hit_cmp2;
	logic hit_latch;
	logic hit_status;
	logic hit_any;
	logic wr_lane0;
	logic [7:0] rd_byte;
	logic [7:0] cmp2_view;
	logic ladder_range_select;
	logic ladder_source_select;
	logic [3:0] ladder_level;
	logic cmp1_ref_select;
	logic cmp2_ref_select;

	// a request is new only while no answer is pending
	assign req = wb_cyc_i && wb_stb_i && (bus_state == CRC_BUS_IDLE);
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

	// address decode
	always_comb
	begin
		hit_ladder = 1'b0;
		hit_cmp2 = 1'b0;
		hit_latch = 1'b0;
		hit_status = 1'b0;
		if (wb_adr_i == `CRC_OFS_LADDER)
			hit_ladder = 1'b1;
		else if (wb_adr_i == `CRC_OFS_CMP2)
			hit_cmp2 = 1'b1;
		else if (wb_adr_i == `CRC_OFS_LATCH)
			hit_latch = 1'b1;
		else if (wb_adr_i == `CRC_OFS_STATUS)
			hit_status = 1'b1;
	end

	assign hit_any = hit_ladder || hit_cmp2 || hit_latch || hit_status;

	// answer one cycle after the request, held one cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			bus_state <= CRC_BUS_IDLE;
		else if (clk_en)
		begin
			case (bus_state)
				CRC_BUS_IDLE:
					if (wb_cyc_i && wb_stb_i)
						bus_state <= CRC_BUS_ACK;
				default:
					bus_state <= CRC_BUS_IDLE;
			endcase
		end
	end

	// ack for mapped addresses, err for unmapped ones
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end
		else if (clk_en)
		begin
			wb_ack_o <= req && hit_any;
			wb_err_o <= req && !hit_any;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			ladder_reference_control <= `CRC_RST_LADDER;
		else if (clk_en && wr_lane0 && hit_ladder)
			ladder_reference_control <= wb_dat_i[7:0];
	end

	// comparator two control, mirror bits are read only
	always_ff @(posedge clk)
	begin
		if (srst)
			comparator_two_control_one <= `CRC_RST_CMP2;
		else if (clk_en && wr_lane0 && hit_cmp2)
			comparator_two_control_one <= wb_dat_i[7:0] & `CRC_CMP_WMASK;
	end

	// pulse bits set by write, cleared next cycle by hardware
	always_ff @(posedge clk)
	begin
		if (srst)
			latch_and_fixed_ref_control <= `CRC_RST_LATCH;
		else if (clk_en)
		begin
			latch_and_fixed_ref_control[`CRC_LAT_PSET] <= 1'b0;
			latch_and_fixed_ref_control[`CRC_LAT_PRST] <= 1'b0;
			if (wr_lane0 && hit_latch)
				latch_and_fixed_ref_control <= wb_dat_i[7:0] & `CRC_LAT_WMASK
					| (wb_dat_i[7:0] & 8'h0C);
		end
	end

	// one-cycle pulses while the bits stand
	assign latch_pulse_set = latch_and_fixed_ref_control[`CRC_LAT_PSET];
	assign latch_pulse_reset = latch_and_fixed_ref_control[`CRC_LAT_PRST];

	// comparator mirror bits shown in the read view
	always_comb
	begin
		cmp2_view = comparator_two_control_one;
		cmp2_view[`CRC_CMP_MC1] = cmp1_out;
		cmp2_view[`CRC_CMP_MC2] = cmp2_out;
	end

	// read mux; status holds the live analog enables
	always_comb
	begin
		if (hit_ladder)
			rd_byte = ladder_reference_control;
		else if (hit_cmp2)
			rd_byte = cmp2_view;
		else if (hit_latch)
			rd_byte = latch_and_fixed_ref_control;
		else if (hit_status)
			rd_byte = {5'h00, fixed_ref_enable, divider_current_enable,
				ladder_enable};
		else
			rd_byte = 8'h00;
	end

	// read data registered, upper bits zero
	always_ff @(posedge clk)
	begin
		if (srst)
			wb_dat_o <= 32'h0000_0000;
		else if (clk_en && req && !wb_we_i)
			wb_dat_o <= {24'h00_0000, rd_byte};
	end

	//--------------------------------------------------
	// field extraction
	//--------------------------------------------------
	assign ladder_range_select = ladder_reference_control[`CRC_LAD_RANGE];
	assign ladder_source_select = ladder_reference_control[`CRC_LAD_SRC];
	assign ladder_level = ladder_reference_control[3:0];
	assign cmp1_ref_select = comparator_two_control_one[`CRC_CMP_SEL1];
	assign cmp2_ref_select = comparator_two_control_one[`CRC_CMP_SEL2];
	assign cmp2_timer_gate_sel = comparator_two_control_one[1];
	assign cmp2_sync_enable = comparator_two_control_one[0];

	//--------------------------------------------------
	// analog control decode
	//--------------------------------------------------
	// static levels from stored bits; fixed reference also from the fast oscillator input
	assign ladder_enable = ladder_reference_control[`CRC_LAD_EN];
	assign ladder_source = ladder_source_select;
	assign ladder_pin_output_enable = ladder_reference_control[`CRC_LAD_OE];
	assign divider_current_enable = cmp1_ref_select || cmp2_ref_select;
	assign fixed_ref_enable =
		latch_and_fixed_ref_control[`CRC_LAT_FIXED] || fast_internal_oscillator;
	// software waits for settling; no hardware delay here

	crc_tap u_tap
	(
		.range_low(ladder_range_select),
		.level(ladder_level),
		.tap_num(ladder_tap_num),
		.tap_den(ladder_tap_den)
	);

	assign cmp1_ref_src = cmp1_ref_select ? CRC_REF_LADDER : CRC_REF_FIXED;
	assign cmp2_ref_src = cmp2_ref_select ? CRC_REF_LADDER : CRC_REF_FIXED;

	always_comb
	begin
		cmp_pos_ref = ladder_source_select ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY;
		if (ladder_source_select
			&& (!ladder_pin_output_enable || adc_neg_ref_cfg))
			cmp_neg_ref = CRC_REF_EXTERNAL;
		else
			cmp_neg_ref = CRC_REF_SUPPLY;
	end

	assign adc_pos_ref = adc_pos_ref_cfg ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY;
	assign adc_neg_ref = adc_neg_ref_cfg ? CRC_REF_EXTERNAL : CRC_REF_SUPPLY;

	always_comb
	begin
		if (adc_neg_ref_cfg)
			ref_minus_pin = CRC_PIN_EXT_REF;
		else if (ladder_pin_output_enable)
			ref_minus_pin = CRC_PIN_LADDER;
		else if (ladder_source_select)
			ref_minus_pin = CRC_PIN_EXT_REF;
		else
			ref_minus_pin = CRC_PIN_GPIO;
	end

	assign ref_plus_pin = adc_pos_ref_cfg || ladder_source_select;

endmodule : crc_ctrl
`default_nettype wire

// >>> verilog/crc_pkg.sv
package crc_pkg;

	// source for each analog reference mux
	typedef enum logic [1:0]
	{
		CRC_REF_SUPPLY = 2'h0,
		CRC_REF_EXTERNAL = 2'h1,
		CRC_REF_LADDER = 2'h2,
		CRC_REF_FIXED = 2'h3
	} crc_ref_t;

	// function of the shared reference-minus pin
	typedef enum logic [1:0]
	{
		CRC_PIN_GPIO = 2'h0,
		CRC_PIN_EXT_REF = 2'h1,
		CRC_PIN_LADDER = 2'h3
	} crc_pin_t;

	// bus slave states, gray coded
	typedef enum logic [1:0]
	{
		CRC_BUS_IDLE = 2'h0,
		CRC_BUS_ACK = 2'h1
	} crc_bus_t;

endpackage : crc_pkg

// >>> verilog/crc_tap.sv
`timescale 1ns/100ps
`default_nettype none
`include "crc_consts.svh"

// ladder tap decoder: numerator over a denominator of the span
module crc_tap
	import crc_pkg::*;
(
	input wire logic range_low,
	input wire logic [3:0] level,
	output logic [7:0] tap_num,
	output logic [7:0] tap_den
);

	// tap fractions of span
	// low: level/24, high: 8/32 + level/32
	always_comb
	begin
		if (range_low)
		begin
			tap_num = {4'h0, level};
			tap_den = `CRC_LOW_DEN;
		end
		else
		begin
			tap_num = `CRC_HIGH_BASE + {4'h0, level};
			tap_den = `CRC_HIGH_DEN;
		end
	end

endmodule : crc_tap
`default_nettype wire
